//--- shared/porc_defines.svh
`ifndef PORC_DEFINES_SVH
`define PORC_DEFINES_SVH

// Clock rate and the acknowledge window, with the window derived in cycles.
`define PORC_CLK_HZ          32'd200000000
`define PORC_HOLD_WINDOW_S   32'd8
`define PORC_HOLD_CYCLES     (`PORC_HOLD_WINDOW_S * `PORC_CLK_HZ)

// Sequence geometry in nonvolatile bank five.
`define PORC_SEQ_LEN         6'd48
`define PORC_BANK_BASE0      7'h00
`define PORC_BANK_BASE1      7'h30

// Reset level encodings.
`define PORC_LVL_POR         2'd0
`define PORC_LVL_HW          2'd1
`define PORC_LVL_SWO         2'd2

// Acknowledge modes.
`define PORC_MODE_HOLD       2'd0
`define PORC_MODE_AUTO       2'd1
`define PORC_MODE_MANUAL     2'd2

// Register byte offsets.
`define PORC_OFF_DEVCTRL     5'h00
`define PORC_OFF_RSTCFG      5'h04
`define PORC_OFF_STATUS      5'h08
`define PORC_OFF_BOOTST      5'h0c
`define PORC_OFF_CAUSE       5'h10
`define PORC_OFF_WARMCFG     5'h14

// Field positions.
`define PORC_DEVON_BIT       0
`define PORC_RSTCFG_HW_BIT   0
`define PORC_RSTCFG_INT_BIT  1
`define PORC_RSTCFG_MODE_LSB 2
`define PORC_CAUSE_TIMEOUT   0
`define PORC_CAUSE_ACKDROP   1
`define PORC_CAUSE_THERMAL   2
`define PORC_CAUSE_SHORT     3

// Synchronised pin indices.
`define PORC_PIN_ON          0
`define PORC_PIN_HOLD        1
`define PORC_PIN_WARM        2
`define PORC_PIN_BOOT        3
`define PORC_PIN_SLEEP       4

`endif

//--- shared/porc_pkg.sv
package porc_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_PWRUP,
        ST_ACTIVE,
        ST_SLEEP,
        ST_PWRDN
    } porc_state_t;

    typedef enum logic [1:0] {
        SEQ_NONE,
        SEQ_OFF_TO_ACTIVE_SEQUENCE,
        SEQ_ACTIVE_TO_OFF_SEQUENCE,
        SEQ_SLEEP_TO_OFF_SEQUENCE
    } porc_seq_kind_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } porc_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } porc_avs_rsp_t;

    typedef struct packed {
        logic           run;
        porc_seq_kind_t kind;
        logic [6:0]     addr;
        logic           sel;
        logic           branchCond;
    } porc_seq_t;

    typedef struct packed {
        porc_state_t    state;
        porc_seq_kind_t seqKind;
        logic           seqRun;
        logic [5:0]     step;
        logic           seqSel;
        logic [6:0]     seqAddr;
        logic           branch;
        logic [4:0]     s1;
        logic [4:0]     s2;
        logic           prevAck;
        logic           prevWarm;
        logic [31:0]    holdCnt;
        logic           holdSeen;
        logic           devOn;
        logic [1:0]     ackMode;
        logic           hwCfg;
        logic           intInSleep;
        logic [3:0]     keepV;
        logic           bootStatus;
        logic [3:0]     cause;
        logic [1:0]     lastLevel;
        logic           resetOut;
        logic           intN;
        logic           hwClr;
        logic           swoClr;
        logic [3:0]     reload;
        logic           waitReq;
        logic [31:0]    rdata;
    } porc_st_t;

endpackage : porc_pkg

//--- verilog/porc_power_ctrl.sv
// Contract
// - Reset output stays asserted until the whole power-up sequence has finished.
// - An ON request starts power-up; reset output is high while ACTIVE.
// - Hold modes: shut down after 8 s in ACTIVE unless acknowledge is high.
// - A falling hold pin is an OFF request.
// - Auto mode sets the device-on bit at power-up end; stays ACTIVE until cleared.
// - Outside hold mode, the device-on bit replaces the hold pin.
// - Boot pin low selects bank five 0x00-0x2F, high selects 0x30-0x5F.
// - Boot pin is latched into boot status at the end of power-up.
// - Boot pin level is offered to the sequencer as a static branch condition.
// - Power-on reset clears every register of all three domains.
// - OFF with hardware reset runs shutdown and clears hardware and switch-off domains.
// - OFF without hardware reset runs shutdown and clears switch-off domain only.
// - Reset levels: 0 power-on, 1 hardware, 2 switch-off.
// - Switch-off cause flags are cleared only by power-on reset or by writing ones to the cause register.
// - Hardware domain holds interrupt, pin, assignment and regulator config.
// - Switch-off domain holds device control and regulator voltage and mode.
// - Interrupt output is active low, low while an unmasked interrupt pends.
// - Interrupt is masked in SLEEP unless configured to stay active.
// - Warm reset pin runs the power-up sequence from ACTIVE or SLEEP.
`include "porc_defines.svh"

module porc_power_ctrl #(
    parameter logic [31:0] HOLD_CYCLES = `PORC_HOLD_CYCLES
) (
    // Clock and power-on reset.
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // Register bus.
    input  wire porc_pkg::porc_avs_req_t avsReq,
    output      porc_pkg::porc_avs_rsp_t avsRsp,
    // Pins from the host and board.
    input  wire logic                   onReqPin,
    input  wire logic                   powerHoldPin,
    input  wire logic                   warmResetPinN,
    input  wire logic                   bootStrapPin,
    input  wire logic                   sleepReqPinN,
    // Events from the regulator and interrupt logic.
    input  wire logic                   thermalEvt,
    input  wire logic                   shortEvt,
    input  wire logic                   intPending,
    // Pins towards the host.
    output      logic                   resetOut,
    output      logic                   intN,
    // Sequencer and register domain control.
    output      porc_pkg::porc_seq_t    seq,
    output      logic                   hwDomainClr,
    output      logic                   swoDomainClr,
    output      logic [1:0]             resetLevel,
    output      logic [3:0]             regReload,
    output      porc_pkg::porc_state_t  devState
);
    import porc_pkg::*;

    porc_st_t   st_r;
    porc_st_t   st_nxt;
    logic       ack;
    logic       timed;
    logic       timeout;
    logic       ackDrop;
    logic       offReq;
    logic       warmFall;
    logic       seqLast;
    logic       busHit;
    logic       wrCommit;

    function automatic logic [31:0] regRead(input logic [4:0] addr, input porc_st_t s);
        logic [31:0] d;
        d = 32'h0;
        unique case (addr)
            `PORC_OFF_DEVCTRL: d[`PORC_DEVON_BIT] = s.devOn;
            `PORC_OFF_RSTCFG: begin
                d[`PORC_RSTCFG_HW_BIT]  = s.hwCfg;
                d[`PORC_RSTCFG_INT_BIT] = s.intInSleep;
                d[`PORC_RSTCFG_MODE_LSB +: 2] = s.ackMode;
            end
            `PORC_OFF_STATUS: d[7:0] = {s.holdSeen, s.lastLevel, s.resetOut, 1'b0, s.state};
            `PORC_OFF_BOOTST: d[0] = s.bootStatus;
            `PORC_OFF_CAUSE: d[3:0] = s.cause;
            `PORC_OFF_WARMCFG: d[3:0] = s.keepV;
            default: d = 32'h0;
        endcase
        return d;
    endfunction : regRead

    always_comb begin
        st_nxt = st_r;
        // Pins from the board pass two flops before any logic looks at them.
        st_nxt.s1 = {sleepReqPinN, bootStrapPin, warmResetPinN, powerHoldPin, onReqPin};
        st_nxt.s2 = st_r.s1;

        // Manual device-on mode follows the hold-pin behaviour with the bit as the pin.
        ack      = (st_r.ackMode == `PORC_MODE_HOLD) ? st_r.s2[`PORC_PIN_HOLD] : st_r.devOn;
        timed    = (st_r.ackMode != `PORC_MODE_AUTO);
        ackDrop  = st_r.prevAck & ~ack;
        timeout  = timed && (st_r.state == ST_ACTIVE) && !st_r.holdSeen
                   && (st_r.holdCnt == HOLD_CYCLES - 32'd1) && !ack;
        offReq   = ((st_r.state == ST_ACTIVE) || (st_r.state == ST_SLEEP))
                   && (timeout || ackDrop || thermalEvt || shortEvt);
        warmFall = st_r.prevWarm & ~st_r.s2[`PORC_PIN_WARM];
        seqLast  = (st_r.step == `PORC_SEQ_LEN - 6'd1);
        st_nxt.prevAck  = ack;
        st_nxt.prevWarm = st_r.s2[`PORC_PIN_WARM];

        st_nxt.hwClr  = 1'b0;
        st_nxt.swoClr = 1'b0;
        st_nxt.reload = 4'h0;
        st_nxt.branch = st_r.s2[`PORC_PIN_BOOT];
        st_nxt.intN   = ~(intPending && !((st_r.state == ST_SLEEP) && !st_r.intInSleep));

        // The window counts only until the acknowledge has been seen once.
        if ((st_r.state == ST_ACTIVE) && timed && !st_r.holdSeen) begin
            st_nxt.holdCnt = st_r.holdCnt + 32'd1;
            if (ack) begin
                st_nxt.holdSeen = 1'b1;
            end
        end

        // One wait cycle per access: data is fetched, then presented with waitrequest low.
        busHit          = avsReq.read | avsReq.write;
        wrCommit        = avsReq.write && !st_r.waitReq && avsReq.byteenable[0];
        st_nxt.waitReq  = !(busHit && st_r.waitReq);
        if (busHit && st_r.waitReq) begin
            st_nxt.rdata = regRead(avsReq.address, st_r);
        end
        if (wrCommit) begin
            unique case (avsReq.address)
                `PORC_OFF_DEVCTRL: st_nxt.devOn = avsReq.writedata[`PORC_DEVON_BIT];
                `PORC_OFF_RSTCFG: begin
                    st_nxt.hwCfg      = avsReq.writedata[`PORC_RSTCFG_HW_BIT];
                    st_nxt.intInSleep = avsReq.writedata[`PORC_RSTCFG_INT_BIT];
                    st_nxt.ackMode    = avsReq.writedata[`PORC_RSTCFG_MODE_LSB +: 2];
                end
                `PORC_OFF_CAUSE: st_nxt.cause = st_r.cause & ~avsReq.writedata[3:0];
                `PORC_OFF_WARMCFG: st_nxt.keepV = avsReq.writedata[3:0];
                default: st_nxt.rdata = st_nxt.rdata;
            endcase
        end

        // Cause flags are set after the software clear so that a same-cycle event wins.
        if ((st_r.state == ST_ACTIVE) || (st_r.state == ST_SLEEP)) begin
            st_nxt.cause = st_nxt.cause | {shortEvt, thermalEvt, ackDrop, timeout};
        end

        unique case (st_r.state)
            ST_OFF: begin
                if (st_r.s2[`PORC_PIN_ON]) begin
                    st_nxt.state    = ST_PWRUP;
                    st_nxt.seqKind  = SEQ_OFF_TO_ACTIVE_SEQUENCE;
                    st_nxt.seqRun   = 1'b1;
                    st_nxt.step     = 6'd0;
                    st_nxt.seqSel   = st_r.s2[`PORC_PIN_BOOT];
                    st_nxt.resetOut = 1'b0;
                end
            end
            ST_PWRUP: begin
                if (seqLast) begin
                    st_nxt.state      = ST_ACTIVE;
                    st_nxt.seqKind    = SEQ_NONE;
                    st_nxt.seqRun     = 1'b0;
                    st_nxt.resetOut   = 1'b1;
                    st_nxt.bootStatus = st_r.s2[`PORC_PIN_BOOT];
                    st_nxt.holdCnt    = 32'd0;
                    st_nxt.holdSeen   = 1'b0;
                    if (st_r.ackMode == `PORC_MODE_AUTO) begin
                        st_nxt.devOn = 1'b1;
                    end
                end else begin
                    st_nxt.step = st_r.step + 6'd1;
                end
            end
            ST_ACTIVE, ST_SLEEP: begin
                if (offReq) begin
                    st_nxt.state    = ST_PWRDN;
                    st_nxt.seqKind  = (st_r.state == ST_ACTIVE) ? SEQ_ACTIVE_TO_OFF_SEQUENCE : SEQ_SLEEP_TO_OFF_SEQUENCE;
                    st_nxt.seqRun   = 1'b1;
                    st_nxt.step     = 6'd0;
                    st_nxt.resetOut = 1'b0;
                end else if (warmFall) begin
                    // Regulators whose keep bit is clear reload their start-up voltage.
                    st_nxt.state    = ST_PWRUP;
                    st_nxt.seqKind  = SEQ_OFF_TO_ACTIVE_SEQUENCE;
                    st_nxt.seqRun   = 1'b1;
                    st_nxt.step     = 6'd0;
                    st_nxt.seqSel   = st_r.s2[`PORC_PIN_BOOT];
                    st_nxt.resetOut = 1'b0;
                    st_nxt.reload   = ~st_r.keepV;
                end else if ((st_r.state == ST_ACTIVE) && !st_r.s2[`PORC_PIN_SLEEP]) begin
                    st_nxt.state = ST_SLEEP;
                end else if ((st_r.state == ST_SLEEP) && st_r.s2[`PORC_PIN_SLEEP]) begin
                    st_nxt.state = ST_ACTIVE;
                end
            end
            ST_PWRDN: begin
                if (seqLast) begin
                    st_nxt.state   = ST_OFF;
                    st_nxt.seqKind = SEQ_NONE;
                    st_nxt.seqRun  = 1'b0;
                    // Device control lives in the switch-off domain and always clears.
                    st_nxt.swoClr  = 1'b1;
                    st_nxt.devOn   = 1'b0;
                    st_nxt.hwClr   = st_r.hwCfg;
                    st_nxt.lastLevel = st_r.hwCfg ? `PORC_LVL_HW : `PORC_LVL_SWO;
                    if (st_r.hwCfg) begin
                        // Cause flags are untouched here so the reason for the stop survives.
                        st_nxt.hwCfg      = 1'b0;
                        st_nxt.intInSleep = 1'b0;
                        st_nxt.ackMode    = `PORC_MODE_HOLD;
                        st_nxt.keepV      = 4'h0;
                    end
                end else begin
                    st_nxt.step = st_r.step + 6'd1;
                end
            end
        endcase

        st_nxt.seqAddr = (st_nxt.seqSel ? `PORC_BANK_BASE1 : `PORC_BANK_BASE0) + {1'b0, st_nxt.step};
    end

    // Power-on reset clears all three domains at once.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r         <= '0;
            st_r.waitReq <= 1'b1;
            st_r.intN    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avsRsp             = '{readdata: st_r.rdata, waitrequest: st_r.waitReq};
    assign resetOut           = st_r.resetOut;
    assign intN               = st_r.intN;
    assign seq                = '{run: st_r.seqRun, kind: st_r.seqKind, addr: st_r.seqAddr,
                                  sel: st_r.seqSel, branchCond: st_r.branch};
    assign hwDomainClr        = st_r.hwClr;
    assign swoDomainClr       = st_r.swoClr;
    assign resetLevel         = st_r.lastLevel;
    assign regReload          = st_r.reload;
    assign devState           = st_r.state;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_reset_during_seq: assert property (st_r.state == ST_PWRUP |-> !st_r.resetOut)
        else $error("reset output released during power-up");
    a_active_released: assert property (st_r.state == ST_ACTIVE |-> st_r.resetOut)
        else $error("reset output low while active");
    a_on_starts_seq: assert property (st_r.state == ST_OFF && st_r.s2[`PORC_PIN_ON]
        |=> st_r.state == ST_PWRUP && st_r.seqKind == SEQ_OFF_TO_ACTIVE_SEQUENCE && st_r.step == 6'd0)
        else $error("on request did not start power-up");
    a_hold_timeout: assert property (timeout |=> st_r.state == ST_PWRDN ##1 st_r.cause[`PORC_CAUSE_TIMEOUT])
        else $error("acknowledge window expiry did not shut down");
    a_ack_fall_off: assert property (st_r.state == ST_ACTIVE && st_r.prevAck && !ack
        |=> st_r.state == ST_PWRDN && st_r.seqKind == SEQ_ACTIVE_TO_OFF_SEQUENCE)
        else $error("acknowledge drop not taken as off request");
    a_auto_devon: assert property (st_r.state == ST_PWRUP && seqLast && st_r.ackMode == `PORC_MODE_AUTO
        |=> st_r.devOn && st_r.state == ST_ACTIVE)
        else $error("device-on bit not set at power-up end");
    a_boot_window: assert property (st_r.seqRun && st_r.seqKind == SEQ_OFF_TO_ACTIVE_SEQUENCE |->
        (st_r.seqSel ? (st_r.seqAddr >= 7'h30 && st_r.seqAddr <= 7'h5f) : (st_r.seqAddr <= 7'h2f)))
        else $error("sequence address outside selected bank window");
    a_boot_latched: assert property (st_r.state == ST_PWRUP && seqLast
        |=> st_r.bootStatus == $past(st_r.s2[`PORC_PIN_BOOT]))
        else $error("boot level not latched at power-up end");
    a_domain_clear: assert property (st_r.state == ST_PWRDN && seqLast
        |=> st_r.swoClr && st_r.hwClr == $past(st_r.hwCfg) && !st_r.devOn ##1 !st_r.swoClr)
        else $error("wrong domains cleared at shutdown end");
    a_level_code: assert property (st_r.swoClr |-> st_r.lastLevel == (st_r.hwClr ? 2'd1 : 2'd2))
        else $error("reset level code mismatch");
    a_cause_kept: assert property (st_r.state == ST_PWRDN && seqLast && !wrCommit
        |=> (st_r.cause & $past(st_r.cause)) == $past(st_r.cause))
        else $error("cause flags lost on domain reset");
    a_int_pending: assert property (intPending && st_r.state == ST_ACTIVE |=> !st_r.intN)
        else $error("interrupt output not driven low");
    a_int_sleep_mask: assert property (st_r.state == ST_SLEEP && !st_r.intInSleep |=> st_r.intN)
        else $error("interrupt not masked in sleep");
    a_warm_restart: assert property (warmFall && !offReq && (st_r.state == ST_ACTIVE || st_r.state == ST_SLEEP)
        |=> st_r.state == ST_PWRUP && st_r.reload == ~$past(st_r.keepV) ##[1:60] st_r.state == ST_ACTIVE)
        else $error("warm reset did not rerun power-up");

    c_power_up: cover property (st_r.state == ST_PWRUP ##1 st_r.state == ST_ACTIVE);
    c_warm: cover property (warmFall && st_r.state == ST_SLEEP);
    c_hw_reset: cover property (st_r.hwClr);
    c_sleep_off: cover property (st_r.seqKind == SEQ_SLEEP_TO_OFF_SEQUENCE);

endmodule : porc_power_ctrl

//--- tb/porc_host_model.sv
module porc_host_model #(
    parameter int ACK_DLY = 20
) (
    // Device status seen by the host.
    input  wire logic ref_clk,
    input  wire logic resetOut,
    // Controls from the bench.
    input  wire logic ackOn,
    input  wire logic bootLvl,
    // Pins towards the device.
    output      logic powerHoldPin,
    output      logic bootStrapPin
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt = 0;

    // The acknowledge comes a while after reset release, well inside the window.
    always @(posedge ref_clk) begin
        if (!ackOn) begin
            cnt <= 0;
        end else if (resetOut && cnt < ACK_DLY) begin
            cnt <= cnt + 1;
        end
    end
    assign powerHoldPin = ackOn && (cnt >= ACK_DLY);
    // The strap follows the bench boot level directly, so it never floats.
    assign bootStrapPin = bootLvl;
endmodule : porc_host_model

//--- tb/tb_power_on_ack_reset_control.sv
module tb_power_on_ack_reset_control;
    timeunit 1ns;
    timeprecision 100ps;
    import porc_pkg::*;

    localparam logic [31:0] HOLD = 32'd200;
    logic ref_clk, rst, onReq, warmN, sleepN, intPending, resetOut, intN;
    logic ackOn, bootLvl, holdPin, bootPin, hwClr, swoClr;
    logic thermalEvt, shortEvt;
    logic [1:0] resetLevel;
    logic [3:0] regReload;
    logic [31:0] q;
    porc_avs_req_t req;
    porc_avs_rsp_t rsp;
    porc_seq_t seq;
    porc_state_t devState;
    int fails = 0;
    int nChecks = 0;

    porc_power_ctrl #(.HOLD_CYCLES(HOLD)) dut (.ref_clk(ref_clk), .rst(rst), .avsReq(req), .avsRsp(rsp),
        .onReqPin(onReq), .powerHoldPin(holdPin), .warmResetPinN(warmN), .bootStrapPin(bootPin),
        .sleepReqPinN(sleepN), .thermalEvt(thermalEvt), .shortEvt(shortEvt), .intPending(intPending),
        .resetOut(resetOut), .intN(intN), .seq(seq), .hwDomainClr(hwClr), .swoDomainClr(swoClr),
        .resetLevel(resetLevel), .regReload(regReload), .devState(devState));
    porc_host_model host (.ref_clk(ref_clk), .resetOut(resetOut), .ackOn(ackOn), .bootLvl(bootLvl),
        .powerHoldPin(holdPin), .bootStrapPin(bootPin));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nChecks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // One bus access; the request stands until waitrequest is sampled low.
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        if (n >= 50) chk(32'h1, 32'h0);
        #1;
    endtask : av

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wait_st(input porc_state_t s, input int lim);
        int n;
        n = 0;
        while (devState !== s && n < lim) begin
            cyc(1);
            n++;
        end
        chk(devState, s);
    endtask : wait_st

    task automatic pwr_up(input logic boot);
        int n, bad;
        n = 0;
        bad = 0;
        bootLvl <= boot;
        cyc(4);
        onReq <= 1'b1;
        wait_st(ST_PWRUP, 20);
        onReq <= 1'b0;
        chk(seq.run, 1'b1);
        chk(seq.addr, boot ? 7'h30 : 7'h00);
        chk(seq.sel, boot);
        chk(seq.branchCond, boot);
        while (devState === ST_PWRUP && n < 100) begin
            if (resetOut !== 1'b0) bad++;
            cyc(1);
            n++;
        end
        chk(n, 48);
        chk(bad, 0);
        chk({devState, resetOut, seq.run}, {ST_ACTIVE, 1'b1, 1'b0});
        av(1'b0, 5'h0c, 0);
        chk(q, boot);
    endtask : pwr_up

    task automatic pwr_dn(input logic [1:0] lvl, input int lim);
        int n;
        logic h, s;
        n = 0;
        h = 1'b0;
        s = 1'b0;
        while (devState !== ST_OFF && n < lim) begin
            cyc(1);
            h |= hwClr;
            s |= swoClr;
            n++;
        end
        chk({devState, resetOut}, {ST_OFF, 1'b0});
        chk(resetLevel, lvl);
        chk(h, lvl == 2'd1);
        chk(s, 1'b1);
    endtask : pwr_dn

    task automatic t_reset;
        chk({devState, resetOut, intN, resetLevel}, {ST_OFF, 1'b0, 1'b1, 2'd0});
        av(1'b0, 5'h10, 0);
        chk(q, 0);
        av(1'b0, 5'h1c, 0);
        chk(q, 0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_timeout;
        pwr_up(1'b0);
        cyc(HOLD - 40);
        chk(devState, ST_ACTIVE);
        pwr_dn(2'd2, 120);
        av(1'b0, 5'h10, 0);
        chk(q[0], 1'b1);
        $display("test hold timeout done");
    endtask : t_timeout

    task automatic t_hold_drop;
        av(1'b1, 5'h04, 32'h1);
        ackOn <= 1'b1;
        pwr_up(1'b1);
        cyc(2 * HOLD);
        chk(devState, ST_ACTIVE);
        ackOn <= 1'b0;
        pwr_dn(2'd1, 80);
        av(1'b0, 5'h04, 0);
        chk(q, 0);
        av(1'b0, 5'h10, 0);
        chk(q[1:0], 2'b11);
        $display("test hold drop done");
    endtask : t_hold_drop

    task automatic t_auto;
        logic [3:0] r;
        av(1'b1, 5'h04, 32'h4);
        pwr_up(1'b0);
        av(1'b0, 5'h00, 0);
        chk(q[0], 1'b1);
        cyc(2 * HOLD);
        chk(devState, ST_ACTIVE);
        intPending <= 1'b1;
        cyc(3);
        chk(intN, 1'b0);
        sleepN <= 1'b0;
        wait_st(ST_SLEEP, 20);
        cyc(2);
        chk(intN, 1'b1);
        av(1'b1, 5'h04, 32'h6);
        cyc(2);
        chk(intN, 1'b0);
        intPending <= 1'b0;
        sleepN <= 1'b1;
        wait_st(ST_ACTIVE, 20);
        chk(intN, 1'b1);
        av(1'b1, 5'h04, 32'h4);
        av(1'b1, 5'h14, 32'h5);
        warmN <= 1'b0;
        r = 4'h0;
        repeat (10) begin
            cyc(1);
            r |= regReload;
        end
        warmN <= 1'b1;
        chk(r, 4'ha);
        chk(resetOut, 1'b0);
        wait_st(ST_ACTIVE, 100);
        av(1'b1, 5'h00, 32'h0);
        pwr_dn(2'd2, 80);
        av(1'b0, 5'h04, 0);
        chk(q, 32'h4);
        av(1'b0, 5'h00, 0);
        chk(q, 0);
        $display("test auto mode done");
    endtask : t_auto

    task automatic t_manual;
        av(1'b1, 5'h04, 32'h8);
        pwr_up(1'b1);
        av(1'b0, 5'h00, 0);
        chk(q, 0);
        av(1'b1, 5'h00, 32'h1);
        cyc(2 * HOLD);
        chk(devState, ST_ACTIVE);
        av(1'b1, 5'h00, 32'h0);
        pwr_dn(2'd2, 80);
        $display("test manual device-on done");
    endtask : t_manual

    // Faults in SLEEP stop the device through the sleep shutdown and leave their cause behind.
    task automatic t_fault;
        av(1'b1, 5'h04, 32'h4);
        pwr_up(1'b0);
        sleepN <= 1'b0;
        wait_st(ST_SLEEP, 20);
        {thermalEvt, shortEvt} <= 2'b11;
        cyc(1);
        {thermalEvt, shortEvt} <= 2'b00;
        chk({devState, seq.kind}, {ST_PWRDN, SEQ_SLEEP_TO_OFF_SEQUENCE});
        sleepN <= 1'b1;
        pwr_dn(2'd2, 80);
        av(1'b0, 5'h10, 0);
        chk(q, 32'hf);
        av(1'b1, 5'h10, 32'hf);
        av(1'b0, 5'h10, 0);
        chk(q, 32'h0);
        $display("test fault stop done");
    endtask : t_fault

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        {onReq, intPending, ackOn, bootLvl} = 4'h0;
        {thermalEvt, shortEvt} = 2'b00;
        {warmN, sleepN} = 2'b11;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_timeout();
        t_hold_drop();
        t_auto();
        t_manual();
        t_fault();
        finish_test();
    end
endmodule : tb_power_on_ack_reset_control
